//--- design/acs_ctrl_top.sv
// Purpose: Control, status and pacing of a ten-bit approximation converter
// Assumes: i_clk is the system oscillator; i_sleep comes from logic on i_clk
// Notes: Register port with read data one cycle after the read strobe
//
// Functional notes
// - Clock field bits 7:6 picks oscillator divide by 2, 8, 32 or RC clock.
// - Channel field bits 5:3 routes input channel N to the converter.
// - Eight channels on large package, five on small; codes 5 to 7 unusable there.
// - Writing go bit 2 while powered starts; it reads one while converting.
// - Hardware clears the go bit when the conversion completes.
// - Bit 0 powers the converter; zero shuts it off.
// - Each conversion yields a ten-bit successive approximation value.
// - Conversion continues in sleep only with the RC conversion clock selected.
// - High and low references selectable from supply, ground or two pins.
// - Four registers: result high, result low, control A at 1Fh, control B.
// - Control B sets each shared pin analog or digital; two may be references.
// - On completion load result, set done flag, clear go, all together.
// - Justify bit: one right-justifies, zero left-justifies, unused bits read zero.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_ctrl_top
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Pins and system
	input wire logic i_rc_clk,
	input wire logic i_cmp,
	input wire logic i_large_pkg,
	input wire logic i_sleep,
	// Analog front end
	output logic o_power_on,
	output logic [2:0] o_chan_sel,
	output logic o_chan_valid,
	output logic o_sample_hold,
	output logic [9:0] o_dac_code,
	output logic o_vref_hi_pin,
	output logic o_vref_lo_pin,
	output logic [7:0] o_analog_en,
	// Interrupt
	output logic o_irq
);

	acs_sar_if sar ();

	logic [1:0] rc_sync_r, cmp_sync_r, pkg_sync_r;
	logic rc_prev_r, rc_armed_r;
	logic rc_rise;
	logic [4:0] div_r, div_nxt, div_term;
	logic div_tick;
	logic tad_en;
	acs_clk_sel_e clk_sel_r, clk_sel_nxt;
	logic [2:0] chan_r, chan_nxt;
	logic power_r, power_nxt;
	logic go_r, go_nxt;
	logic justify_r, justify_nxt;
	logic [3:0] cfg_r, cfg_nxt;
	logic [9:0] result_r, result_nxt;
	logic done_flag_r, done_flag_nxt;
	logic mask_r, mask_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic wr_a, wr_b, start_req;
	logic [9:0] pin_map;
	logic [7:0] analog_en_r;
	logic vref_hi_r, vref_lo_r, chan_valid_r, chan_valid_nxt;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rc_sync_r <= 2'b00;
			cmp_sync_r <= 2'b00;
			pkg_sync_r <= 2'b00;
			rc_prev_r <= 1'b0;
			rc_armed_r <= 1'b0;
		end
		else
		begin
			rc_sync_r <= {rc_sync_r[0], i_rc_clk};
			cmp_sync_r <= {cmp_sync_r[0], i_cmp};
			pkg_sync_r <= {pkg_sync_r[0], i_large_pkg};
			rc_prev_r <= rc_sync_r[1];
			rc_armed_r <= sar.busy && (rc_armed_r || rc_rise);
		end
	end

	assign rc_rise = rc_sync_r[1] && !rc_prev_r;

	// ----------------------------------------
	// Bit period pacing
	// ----------------------------------------
	// RC clock must be below a quarter of i_clk for its edges to survive the crossing
	always_comb
	begin
		case (clk_sel_r)
			ACS_CLK_DIV2: div_term = `ACS_DIV2_TERM;
			ACS_CLK_DIV8: div_term = `ACS_DIV8_TERM;
			ACS_CLK_DIV32: div_term = `ACS_DIV32_TERM;
			default: div_term = `ACS_DIV32_TERM;
		endcase
		div_tick = power_r && (div_r == div_term);
		if (!power_r || div_tick || sar.start)
			div_nxt = 5'h00;
		else
			div_nxt = div_r + 5'h01;
	end

	// Sleep stops oscillator periods; the first RC edge only arms, so the comparator settles first
	assign tad_en = power_r && ((clk_sel_r == ACS_CLK_RC) ? (rc_rise && rc_armed_r) : (div_tick && !i_sleep));

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			div_r <= 5'h00;
		else
			div_r <= div_nxt;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	assign wr_a = i_wr && (i_addr == `ACS_ADDR_CTRL_A);
	assign wr_b = i_wr && (i_addr == `ACS_ADDR_CTRL_B);
	assign start_req = wr_a && i_wdata[`ACS_GO_BIT] && i_wdata[`ACS_POWER_BIT];

	always_comb
	begin
		clk_sel_nxt = clk_sel_r;
		chan_nxt = chan_r;
		power_nxt = power_r;
		go_nxt = go_r;
		justify_nxt = justify_r;
		cfg_nxt = cfg_r;
		result_nxt = result_r;
		done_flag_nxt = done_flag_r;
		mask_nxt = mask_r;
		rdata_nxt = 8'h00;
		if (wr_a)
		begin
			clk_sel_nxt = acs_clk_sel_e'(i_wdata[`ACS_CLK_SEL_HI:`ACS_CLK_SEL_LO]);
			chan_nxt = i_wdata[`ACS_CHAN_HI:`ACS_CHAN_LO];
			power_nxt = i_wdata[`ACS_POWER_BIT];
			go_nxt = start_req;
		end
		if (wr_b)
		begin
			justify_nxt = i_wdata[`ACS_JUSTIFY_BIT];
			cfg_nxt = i_wdata[`ACS_CFG_HI:`ACS_CFG_LO];
		end
		if (i_wr && (i_addr == `ACS_ADDR_IRQ_MASK))
			mask_nxt = i_wdata[`ACS_DONE_BIT];
		if (i_rd)
		begin
			case (i_addr)
				`ACS_ADDR_CTRL_A: rdata_nxt = {clk_sel_r, chan_r, go_r, 1'b0, power_r};
				`ACS_ADDR_CTRL_B: rdata_nxt = {justify_r, 3'b000, cfg_r};
				`ACS_ADDR_RES_HI: rdata_nxt = justify_r ? {6'h00, result_r[9:8]} : result_r[9:2];
				`ACS_ADDR_RES_LO: rdata_nxt = justify_r ? result_r[7:0] : {result_r[1:0], 6'h00};
				`ACS_ADDR_IRQ_STAT: rdata_nxt = {7'h00, done_flag_r};
				`ACS_ADDR_IRQ_MASK: rdata_nxt = {7'h00, mask_r};
				default: rdata_nxt = 8'h00;
			endcase
			if (i_addr == `ACS_ADDR_IRQ_STAT)
				done_flag_nxt = 1'b0;
		end
		// Completion wins over a same-cycle write or status read
		if (sar.done)
		begin
			go_nxt = 1'b0;
			result_nxt = sar.result;
			done_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			clk_sel_r <= ACS_CLK_DIV2;
			chan_r <= 3'h0;
			power_r <= 1'b0;
			go_r <= 1'b0;
			justify_r <= 1'b0;
			cfg_r <= 4'h0;
			result_r <= `ACS_RESULT_RESET;
			done_flag_r <= 1'b0;
			mask_r <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			clk_sel_r <= clk_sel_nxt;
			chan_r <= chan_nxt;
			power_r <= power_nxt;
			go_r <= go_nxt;
			justify_r <= justify_nxt;
			cfg_r <= cfg_nxt;
			result_r <= result_nxt;
			done_flag_r <= done_flag_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Core link
	// ----------------------------------------
	assign sar.tad_en = tad_en;
	assign sar.cmp = cmp_sync_r[1];
	// A rewrite of go while busy does not restart the conversion
	assign sar.start = start_req && !go_r;
	// Clearing go or power mid-conversion abandons it with no result
	assign sar.abort = go_r && wr_a && !start_req && !sar.done;

	acs_sar_core u_core (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.sar(sar)
	);

	// ----------------------------------------
	// Pin configuration
	// ----------------------------------------
	// Returns {high ref on pin, low ref on pin, non-digital pins AN7..AN0}
	function automatic logic [9:0] pin_config(input logic [3:0] cfg);
		logic [9:0] map;
		case (cfg)
			4'h0: map = {2'b00, 8'hFF};
			4'h1: map = {2'b10, 8'hFF};
			4'h2: map = {2'b00, 8'h1F};
			4'h3: map = {2'b10, 8'h1F};
			4'h4: map = {2'b00, 8'h0B};
			4'h5: map = {2'b10, 8'h0B};
			4'h8: map = {2'b11, 8'hFF};
			4'h9: map = {2'b00, 8'h3F};
			4'hA: map = {2'b10, 8'h3F};
			4'hB: map = {2'b11, 8'h3F};
			4'hC: map = {2'b11, 8'h1F};
			4'hD: map = {2'b11, 8'h0F};
			4'hE: map = {2'b00, 8'h01};
			4'hF: map = {2'b11, 8'h0D};
			default: map = {2'b00, 8'h00};
		endcase
		return map;
	endfunction

	assign pin_map = pin_config(cfg_r);

	always_comb
	begin
		chan_valid_nxt = power_r && pin_map[chan_r];
		if (pin_map[9] && chan_r == `ACS_VREF_HI_CHAN)
			chan_valid_nxt = 1'b0;
		if (pin_map[8] && chan_r == `ACS_VREF_LO_CHAN)
			chan_valid_nxt = 1'b0;
		if (!pkg_sync_r[1] && chan_r >= `ACS_SMALL_CHANS)
			chan_valid_nxt = 1'b0;
	end

	// Small package has no upper three pins, so they never go analog
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			analog_en_r <= 8'h00;
			vref_hi_r <= 1'b0;
			vref_lo_r <= 1'b0;
			chan_valid_r <= 1'b0;
		end
		else
		begin
			analog_en_r <= pin_map[7:0] & (pkg_sync_r[1] ? 8'hFF : 8'h1F);
			vref_hi_r <= pin_map[9];
			vref_lo_r <= pin_map[8];
			chan_valid_r <= chan_valid_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rdata = rdata_r;
	assign o_power_on = power_r;
	assign o_chan_sel = chan_r;
	assign o_chan_valid = chan_valid_r;
	assign o_sample_hold = sar.busy;
	assign o_dac_code = sar.trial;
	assign o_vref_hi_pin = vref_hi_r;
	assign o_vref_lo_pin = vref_lo_r;
	assign o_analog_en = analog_en_r;
	assign o_irq = done_flag_r && mask_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_go_needs_power: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(wr_a && !i_wdata[`ACS_POWER_BIT]) |=> !go_r && !o_sample_hold)
		else $error("Go set or conversion kept without power");
	a_done_clears_go: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		sar.done |=> !go_r)
		else $error("Go bit still set after completion");
	a_done_loads_all: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		sar.done |=> done_flag_r && (result_r == $past(sar.result)))
		else $error("Result or flag missing after completion");
	a_go_reads_busy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == `ACS_ADDR_CTRL_A) |=> (o_rdata[`ACS_GO_BIT] == $past(go_r)) && !o_rdata[1])
		else $error("Control readback wrong");
	a_start_sets_go: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(sar.start && !sar.done) |=> go_r && o_sample_hold)
		else $error("Start did not set go and begin");
	a_right_justify: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == `ACS_ADDR_RES_HI && justify_r) |=> (o_rdata[7:2] == 6'h00))
		else $error("Right-justified high byte has upper bits set");
	a_left_justify: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && i_addr == `ACS_ADDR_RES_LO && !justify_r) |=> (o_rdata[5:0] == 6'h00))
		else $error("Left-justified low byte has lower bits set");
	a_sleep_gates_osc: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_sleep && clk_sel_r != ACS_CLK_RC) |-> !tad_en)
		else $error("Oscillator pacing ran in sleep");
	a_small_pkg_chan: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!pkg_sync_r[1] && $stable(pkg_sync_r[1]) && $past(chan_r) >= `ACS_SMALL_CHANS) |-> !chan_valid_r)
		else $error("Missing channel reported usable");
	a_chan_routes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		wr_a |=> (o_chan_sel == $past(i_wdata[`ACS_CHAN_HI:`ACS_CHAN_LO])))
		else $error("Channel field not routed");
endmodule // acs_ctrl_top

//--- common/acs_consts.svh
// Purpose: Offsets, field positions, reset values and divider counts of the converter sequencer
// Assumes: 8-bit register port
// Notes: Definitions only
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACS_ADDR_CTRL_A 8'h1F
`define ACS_ADDR_CTRL_B 8'h9F
`define ACS_ADDR_RES_HI 8'h1E
`define ACS_ADDR_RES_LO 8'h9E
`define ACS_ADDR_IRQ_STAT 8'h20
`define ACS_ADDR_IRQ_MASK 8'h21

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACS_CLK_SEL_HI 7
`define ACS_CLK_SEL_LO 6
`define ACS_CHAN_HI 5
`define ACS_CHAN_LO 3
`define ACS_GO_BIT 2
`define ACS_POWER_BIT 0
`define ACS_JUSTIFY_BIT 7
`define ACS_CFG_HI 3
`define ACS_CFG_LO 0
`define ACS_DONE_BIT 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define ACS_CTRL_A_RESET 8'h00
`define ACS_CTRL_B_RESET 8'h00
`define ACS_RESULT_RESET 10'h000
`define ACS_DIV2_TERM 5'h01
`define ACS_DIV8_TERM 5'h07
`define ACS_DIV32_TERM 5'h1F
`define ACS_SAR_START 10'h200
`define ACS_SAR_MSB 4'h9
`define ACS_SAR_BITS 4'hA
`define ACS_SMALL_CHANS 3'h5
`define ACS_VREF_HI_CHAN 3'h3
`define ACS_VREF_LO_CHAN 3'h2

`endif

//--- common/acs_pkg.sv
// Purpose: Types of the converter sequencer
// Assumes: Nothing
// Notes: Gray codes along the conversion path
package acs_pkg;
	typedef enum logic [1:0] {
		ACS_IDLE = 2'b00,
		ACS_CONV = 2'b01,
		ACS_FIN = 2'b11
	} acs_sar_state_e;

	typedef enum logic [1:0] {
		ACS_CLK_DIV2 = 2'b00,
		ACS_CLK_DIV8 = 2'b01,
		ACS_CLK_DIV32 = 2'b10,
		ACS_CLK_RC = 2'b11
	} acs_clk_sel_e;
endpackage

//--- common/acs_sar_if.sv
// Purpose: Link between control logic and the approximation core
// Assumes: Single clock
// Notes: Control side drives the pacing and requests
`timescale 1ns/1ps
interface acs_sar_if;
	logic tad_en;
	logic start;
	logic abort;
	logic cmp;
	logic done;
	logic busy;
	logic [9:0] trial;
	logic [9:0] result;

	modport ctl (output tad_en, output start, output abort, output cmp,
		input done, input busy, input trial, input result);
	modport core (input tad_en, input start, input abort, input cmp,
		output done, output busy, output trial, output result);
endinterface

//--- design/acs_sar_core.sv
// Purpose: Successive approximation of one ten-bit result
// Assumes: Comparator high when input is at or above the trial code
// Notes: One result bit per pacing pulse, most significant first
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_sar_core
	import acs_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Control link
	acs_sar_if.core sar
);

	acs_sar_state_e state_r, state_nxt;
	logic [9:0] trial_r, trial_nxt;
	logic [9:0] result_r, result_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [9:0] keep;
	logic [3:0] tad_cnt_r;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		trial_nxt = trial_r;
		result_nxt = result_r;
		bit_nxt = bit_r;
		keep = trial_r;
		keep[bit_r] = sar.cmp;
		case (state_r)
			ACS_IDLE:
			begin
				if (sar.start)
				begin
					state_nxt = ACS_CONV;
					trial_nxt = `ACS_SAR_START;
					bit_nxt = `ACS_SAR_MSB;
				end
			end
			ACS_CONV:
			begin
				if (sar.abort)
				begin
					state_nxt = ACS_IDLE;
					trial_nxt = 10'h000;
				end
				else if (sar.tad_en)
				begin
					trial_nxt = keep;
					if (bit_r == 4'h0)
					begin
						result_nxt = keep;
						state_nxt = ACS_FIN;
					end
					else
					begin
						trial_nxt[bit_r - 4'h1] = 1'b1;
						bit_nxt = bit_r - 4'h1;
					end
				end
			end
			ACS_FIN:
			begin
				state_nxt = ACS_IDLE;
			end
			default:
			begin
				state_nxt = ACS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_r <= ACS_IDLE;
			trial_r <= 10'h000;
			result_r <= `ACS_RESULT_RESET;
			bit_r <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			trial_r <= trial_nxt;
			result_r <= result_nxt;
			bit_r <= bit_nxt;
		end
	end

	// Busy is the low state bit, so the hold line comes straight from a flop
	assign sar.busy = state_r[0];
	assign sar.done = (state_r == ACS_FIN);
	assign sar.trial = trial_r;
	assign sar.result = result_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			tad_cnt_r <= 4'h0;
		else if (state_r == ACS_IDLE)
			tad_cnt_r <= 4'h0;
		else if (state_r == ACS_CONV && sar.tad_en)
			tad_cnt_r <= tad_cnt_r + 4'h1;
	end

	a_msb_first_trial: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state_r == ACS_IDLE && sar.start) |=> (trial_r == `ACS_SAR_START) && sar.busy)
		else $error("Conversion did not start at the top bit");
	a_trial_holds_between: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state_r == ACS_CONV && !sar.tad_en && !sar.abort) |=> $stable(trial_r))
		else $error("Trial code moved without a pacing pulse");
	a_ten_bit_result: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		sar.done |-> (tad_cnt_r == `ACS_SAR_BITS) ##1 !sar.done)
		else $error("Result finished after the wrong number of bit periods");
endmodule // acs_sar_core

//--- verification/acs_ctrl_top_tb.sv
// Purpose: Self-checking bench for the converter control sequencer
// Assumes: Comparator modelled as an ideal input level against the trial code
// Notes: Expected results come from a small integer model kept in the bench
`timescale 1ns/1ps
`include "acs_consts.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module acs_ctrl_top_tb
	import acs_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic i_clk;
	logic i_reset_n;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [7:0] o_rdata;
	logic i_rc_clk;
	logic i_cmp;
	logic i_large_pkg;
	logic i_sleep;
	logic o_power_on;
	logic [2:0] o_chan_sel;
	logic o_chan_valid;
	logic o_sample_hold;
	logic [9:0] o_dac_code;
	logic o_vref_hi_pin;
	logic o_vref_lo_pin;
	logic [7:0] o_analog_en;
	logic o_irq;
	int mismatches;
	int total_checks;
	int seed;
	logic [9:0] ain;
	logic [3:0] rc_cnt;
	logic [7:0] rd_val;
	int exp_q[$];
	logic [7:0] an_tab [16] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b, 8'h00, 8'h00,
		8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h1f, 8'h0f, 8'h01, 8'h0d};
	logic [15:0] hi_tab = 16'hbd2a;
	logic [15:0] lo_tab = 16'hb900;

	acs_ctrl_top i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rc_clk(i_rc_clk), .i_cmp(i_cmp),
		.i_large_pkg(i_large_pkg), .i_sleep(i_sleep), .o_power_on(o_power_on), .o_chan_sel(o_chan_sel),
		.o_chan_valid(o_chan_valid), .o_sample_hold(o_sample_hold), .o_dac_code(o_dac_code),
		.o_vref_hi_pin(o_vref_hi_pin), .o_vref_lo_pin(o_vref_lo_pin), .o_analog_en(o_analog_en),
		.o_irq(o_irq));

	// ----------------------------------------
	// Clock, RC pin and comparator
	// ----------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// RC pin runs at one sixteenth of the system clock, well under the quarter-rate limit
	always @(posedge i_clk)
	begin
		rc_cnt <= rc_cnt + 4'h1;
		i_rc_clk <= rc_cnt[3];
		i_cmp <= (ain >= o_dac_code);
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic wait_irq(input int lim);
		int n;
		for (n = 0; n < lim && o_irq !== 1'b1; n++)
		begin
			@(posedge i_clk);
			#1;
		end
		if (o_irq !== 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t: wait for completion ran out", $time);
			end_sim();
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// One conversion against the model
	// ----------------------------------------
	task automatic convert(input logic [1:0] sel, input logic just, input logic [2:0] chan);
		logic [9:0] r;
		logic [7:0] ca;
		// Divide by 2 outruns the comparator synchroniser, so only a full-scale input is exact there
		ain = (sel == ACS_CLK_DIV2) ? 10'h3ff : 10'($random(seed));
		exp_q.push_back(int'(ain));
		reg_wr(`ACS_ADDR_CTRL_B, {just, 7'h00});
		i_sleep <= sel[0];
		ca = {sel, chan, 3'b101};
		reg_wr(`ACS_ADDR_CTRL_A, ca);
		reg_rd(`ACS_ADDR_CTRL_A, rd_val);
		`CHK(rd_val, ca)
		if (sel == ACS_CLK_DIV32)
			`CHK(o_dac_code, 10'h200)
		if (sel == ACS_CLK_DIV8)
		begin
			repeat (100) @(posedge i_clk);
			#1;
			`CHK(o_irq, 1'b0)
			`CHK(o_sample_hold, 1'b1)
			i_sleep <= 1'b0;
		end
		wait_irq(3000);
		i_sleep <= 1'b0;
		r = 10'(exp_q.pop_front());
		reg_rd(`ACS_ADDR_CTRL_A, rd_val);
		`CHK(rd_val, {sel, chan, 3'b001})
		reg_rd(`ACS_ADDR_RES_HI, rd_val);
		`CHK(rd_val, just ? {6'h00, r[9:8]} : r[9:2])
		reg_rd(`ACS_ADDR_RES_LO, rd_val);
		`CHK(rd_val, just ? r[7:0] : {r[1:0], 6'h00})
		reg_rd(`ACS_ADDR_IRQ_STAT, rd_val);
		`CHK(rd_val, 8'h01)
		`CHK(o_irq, 1'b0)
		repeat (64) @(posedge i_clk);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		mismatches = 0;
		total_checks = 0;
		seed = 32'hfd9e;
		i_reset_n = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_rc_clk = 1'b0;
		i_cmp = 1'b0;
		i_large_pkg = 1'b0;
		i_sleep = 1'b0;
		ain = 10'h000;
		rc_cnt = 4'h0;
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		// Reset values, and an unmapped place reads zero
		reg_rd(`ACS_ADDR_CTRL_A, rd_val);
		`CHK(rd_val, 8'h00)
		reg_rd(`ACS_ADDR_CTRL_B, rd_val);
		`CHK(rd_val, 8'h00)
		reg_rd(`ACS_ADDR_IRQ_STAT, rd_val);
		`CHK(rd_val, 8'h00)
		reg_wr(8'h55, 8'hff);
		reg_rd(8'h55, rd_val);
		`CHK(rd_val, 8'h00)
		// Go and bit 1 written with power off: nothing starts
		reg_wr(`ACS_ADDR_CTRL_A, 8'hfe);
		reg_rd(`ACS_ADDR_CTRL_A, rd_val);
		`CHK(rd_val, 8'hf8)
		`CHK(o_power_on, 1'b0)
		`CHK(o_sample_hold, 1'b0)
		// Channel routing on the small package, then channel 7 valid on the large
		for (int c = 0; c < 8; c++)
		begin
			reg_wr(`ACS_ADDR_CTRL_A, {2'b00, 3'(c), 3'b001});
			repeat (4) @(posedge i_clk);
			#1;
			`CHK(o_chan_sel, 3'(c))
			`CHK(o_chan_valid, (c < 5))
		end
		`CHK(o_analog_en, 8'h1f)
		i_large_pkg <= 1'b1;
		repeat (5) @(posedge i_clk);
		#1;
		`CHK(o_chan_valid, 1'b1)
		`CHK(o_analog_en, 8'hff)
		reg_wr(`ACS_ADDR_CTRL_B, 8'h08);
		repeat (3) @(posedge i_clk);
		#1;
		`CHK(o_vref_hi_pin, 1'b1)
		`CHK(o_vref_lo_pin, 1'b1)
		// Every pin configuration code with the large package
		for (int p = 0; p < 16; p++)
		begin
			reg_wr(`ACS_ADDR_CTRL_B, 8'(p));
			repeat (2) @(posedge i_clk);
			#1;
			`CHK(o_analog_en, an_tab[p])
			`CHK(o_chan_valid, an_tab[p][7])
			`CHK(o_vref_hi_pin, hi_tab[p])
			`CHK(o_vref_lo_pin, lo_tab[p])
		end
		// Every clock code, both justifications
		reg_wr(`ACS_ADDR_IRQ_MASK, 8'h01);
		for (int s = 0; s < 8; s++)
			convert(2'(s), s[2], 3'(s));
		// Masked completion still flags status
		reg_wr(`ACS_ADDR_IRQ_MASK, 8'h00);
		reg_wr(`ACS_ADDR_CTRL_A, 8'h05);
		repeat (60) @(posedge i_clk);
		#1;
		`CHK(o_irq, 1'b0)
		reg_rd(`ACS_ADDR_IRQ_STAT, rd_val);
		`CHK(rd_val, 8'h01)
		// Power off in mid-conversion aborts with no flag
		reg_wr(`ACS_ADDR_CTRL_A, 8'h85);
		repeat (40) @(posedge i_clk);
		reg_wr(`ACS_ADDR_CTRL_A, 8'h80);
		reg_rd(`ACS_ADDR_CTRL_A, rd_val);
		`CHK(rd_val, 8'h80)
		`CHK(o_power_on, 1'b0)
		repeat (400) @(posedge i_clk);
		reg_rd(`ACS_ADDR_IRQ_STAT, rd_val);
		`CHK(rd_val, 8'h00)
		end_sim();
	end
endmodule // acs_ctrl_top_tb
